// ### rtl/rcs_map.vh
// Constants for the reset, clock and stack control block.
// Included by rtl/rcs_ctrl.v and rtl/rcs_clkdiv.v; no logic here.
// Functional notes
// RL1: Reset clears requests, sets every mask
// RL2: Reset clears all port direction bits
// RL3: Reset loads stack pointer with 7F
// RL4: Reset clears halt and idle latches
// RL5: After reset, fetch vector into PC
// RL6: Reset from power-up or low pin
// RL7: Supply-drop detector forces a reset
// RL8: Static variant stretches reset 1920 cycles
// RL9: Pin still low holds reset longer
// RL10: External reset exits halt and idle
// RL11: Power-on reset only on rising supply
// RL12: Dynamic variant divides oscillator by four
// RL13: Static variant option picks two or four
// RL14: Option register bit picks crystal/resistor
// RL15: Stack is LIFO, pointer at next free
// RL16: Push past limit wraps pointer to 7F
// RL17: Interrupt pushes five, call pushes two
// RL18: RAM and stack within first 128 addresses
// RL19: Stack pointer and PC 11 to 13 bits
// RL20: Peripheral registers in shared memory map
// RL21: External reset synchronised before release
`ifndef RCS_MAP_VH
`define RCS_MAP_VH

`define RCS_PC_W          13
`define RCS_SP_TOP        13'h007F
`define RCS_SP_LIMIT      13'h0060
`define RCS_RAM_TOP_ADDR  13'h007F
`define RCS_POR_CYCLES    11'd1920
`define RCS_INTR_PUSH     3'd5
`define RCS_CALL_PUSH     3'd2
`define RCS_VEC_HI        13'h1FFE
`define RCS_VEC_LO        13'h1FFF

`define RCS_REG_CTRL      8'h00
`define RCS_REG_STATUS    8'h04
`define RCS_REG_SP        8'h08
`define RCS_REG_PC        8'h0C
`define RCS_REG_IRQ       8'h10
`define RCS_REG_DDR       8'h14

`define RCS_CTRL_RST      32'h0000_0000
`define RCS_CTRL_OSCSEL   0
`define RCS_CTRL_DIV2     1
`define RCS_CTRL_HALT     2
`define RCS_CTRL_IDLE     3
`define RCS_CTRL_SWRST    4
`define RCS_ST_INRST      0
`define RCS_ST_HALT       1
`define RCS_ST_IDLE       2
`define RCS_ST_VECOK      3
`define RCS_ST_PORDONE    4

`define RCS_SP_PUSH1      3'd1
`define RCS_SP_POP1       3'd2
`define RCS_SP_INTR       3'd3
`define RCS_SP_CALL       3'd4
`define RCS_SP_RTI        3'd5
`define RCS_SP_RTS        3'd6

`endif

// ### rtl/rcs_clkdiv.v
// Internal system clock enable: oscillator divided by two or four.
// Runs on the oscillator clock; produces one-cycle enable pulses.
`timescale 1ns/1ns
`include "rcs_map.vh"
module rcs_clkdiv (
    input  wire       mclk_in,
    input  wire       rst_b_in,
    input  wire       ce_in,
    input  wire       div2_in,
    output reg        tick_out
);
    reg  [1:0] cnt_r;
    wire [1:0] lim;

    assign lim = div2_in ? 2'd1 : 2'd3;   // [RL12] [RL13]

    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_r    <= 2'd0;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            if (cnt_r >= lim) begin
                cnt_r    <= 2'd0;
                tick_out <= 1'b1;
            end else begin
                cnt_r    <= cnt_r + 2'd1;
                tick_out <= 1'b0;
            end
        end
    end
endmodule // rcs_clkdiv

// ### rtl/rcs_ctrl.v
// Reset sequencer, clock divider control and stack pointer for a small core.
// Registers reached over AHB-Lite; reset pin and supply-drop detector are
// asynchronous pins and are synchronised here.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "rcs_map.vh"
module rcs_ctrl #(
    parameter STATIC_VARIANT = 1'b1,
    parameter DIV2_OPTION    = 1'b0
) (
    input  wire        mclk_in,
    input  wire        rst_b_in,
    input  wire        ce_in,
    input  wire        ext_reset_b_in,
    input  wire        supply_drop_detector_in,
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    input  wire [2:0]  sp_op_in,
    input  wire [7:0]  irq_set_in,
    output reg         core_reset_out,
    output reg         vec_fetch_out,
    output reg  [12:0] vec_addr_out,
    input  wire [7:0]  vec_data_in,
    input  wire        vec_valid_in,
    output reg  [12:0] pc_out,
    output reg  [12:0] sp_out,
    output reg  [7:0]  irq_pend_out,
    output reg  [7:0]  irq_mask_out,
    output reg  [7:0]  ddr_out,
    output reg         halt_out,
    output reg         idle_out,
    output wire        osc_xtal_sel_out,
    output wire        sys_tick_out
);
    localparam ST_POR   = 3'd0;
    localparam ST_HOLD  = 3'd1;
    localparam ST_VECHI = 3'd2;
    localparam ST_VECLO = 3'd3;
    localparam ST_RUN   = 3'd4;

    // Stack pointer next value; keeps it inside the top page of RAM.
    function [12:0] sp_move;
        input [12:0] sp;
        input [2:0]  dec;
        input [2:0]  inc;
        reg   [12:0] t;
        begin
            t = sp - {10'd0, dec} + {10'd0, inc};
            if (t > `RCS_SP_TOP || t < `RCS_SP_LIMIT)
                sp_move = `RCS_SP_TOP;                // [RL16] [RL18]
            else
                sp_move = t;
        end
    endfunction

    reg        pin_s1_r, pin_s2_r, drop_s1_r, drop_s2_r;
    reg [2:0]  state_r;
    reg [10:0] por_cnt_r;
    reg        por_done_r;
    reg [7:0]  ctrl_r;
    reg        swrst_r;
    reg        vec_ok_r;
    reg [7:0]  vec_hi_r;
    reg        dph_r, dph_wr_r;
    reg [7:0]  dph_addr_r;
    wire       any_rst;
    wire       tick;
    wire       wr_ok;

    // Pins cross into the clock domain through two flops each.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1_r  <= 1'b0;
            pin_s2_r  <= 1'b0;
            drop_s1_r <= 1'b1;
            drop_s2_r <= 1'b1;
        end else if (ce_in) begin
            pin_s1_r  <= ext_reset_b_in;                // [RL21]
            pin_s2_r  <= pin_s1_r;
            drop_s1_r <= supply_drop_detector_in;
            drop_s2_r <= drop_s1_r;
        end
    end

    // Power-on reset comes only from rst_b_in rising, never from a supply fall.
    assign any_rst = !pin_s2_r || drop_s2_r || swrst_r; // [RL6] [RL7] [RL11]

    rcs_clkdiv u_div (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .div2_in  (STATIC_VARIANT ? DIV2_OPTION : 1'b0), // [RL12] [RL13]
        .tick_out (tick)
    );
    assign sys_tick_out     = tick;
    assign osc_xtal_sel_out = ctrl_r[`RCS_CTRL_OSCSEL];  // [RL14]

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign wr_ok = dph_r && dph_wr_r;

    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r        <= ST_POR;
            por_cnt_r      <= 11'd0;
            por_done_r     <= 1'b0;
            core_reset_out <= 1'b1;
            vec_fetch_out  <= 1'b0;
            vec_addr_out   <= `RCS_VEC_HI;
            vec_hi_r       <= 8'h00;
            vec_ok_r       <= 1'b0;
            pc_out         <= 13'h0000;
            sp_out         <= `RCS_SP_TOP;
            irq_pend_out   <= 8'h00;
            irq_mask_out   <= 8'hFF;
            ddr_out        <= 8'h00;
            halt_out       <= 1'b0;
            idle_out       <= 1'b0;
            ctrl_r         <= 8'h00;
            swrst_r        <= 1'b0;
            dph_r          <= 1'b0;
            dph_wr_r       <= 1'b0;
            dph_addr_r     <= 8'h00;
        end else if (ce_in) begin
            dph_r      <= hsel_in && hready_in && htrans_in[1];
            dph_wr_r   <= hwrite_in;
            dph_addr_r <= haddr_in[7:0];
            swrst_r    <= 1'b0;
            if (wr_ok && dph_addr_r == `RCS_REG_CTRL) begin
                ctrl_r  <= hwdata_in[7:0];
                swrst_r <= hwdata_in[`RCS_CTRL_SWRST];
            end
            if (state_r == ST_RUN) begin
                if (wr_ok && dph_addr_r == `RCS_REG_CTRL) begin
                    halt_out <= hwdata_in[`RCS_CTRL_HALT];
                    idle_out <= hwdata_in[`RCS_CTRL_IDLE];
                end
                if (wr_ok && dph_addr_r == `RCS_REG_IRQ)
                    irq_mask_out <= hwdata_in[15:8];
                if (wr_ok && dph_addr_r == `RCS_REG_DDR)
                    ddr_out <= hwdata_in[7:0];
                // New requests win over a software clear in the same cycle.
                if (wr_ok && dph_addr_r == `RCS_REG_IRQ)
                    irq_pend_out <= (irq_pend_out & ~hwdata_in[7:0]) | irq_set_in;
                else
                    irq_pend_out <= irq_pend_out | irq_set_in;
                if (tick) begin
                    case (sp_op_in)                                   // [RL15]
                        `RCS_SP_PUSH1: sp_out <= sp_move(sp_out, 3'd1, 3'd0);
                        `RCS_SP_POP1:  sp_out <= sp_move(sp_out, 3'd0, 3'd1);
                        `RCS_SP_INTR:  sp_out <= sp_move(sp_out, `RCS_INTR_PUSH, 3'd0); // [RL17]
                        `RCS_SP_CALL:  sp_out <= sp_move(sp_out, `RCS_CALL_PUSH, 3'd0); // [RL17]
                        `RCS_SP_RTI:   sp_out <= sp_move(sp_out, 3'd0, `RCS_INTR_PUSH);
                        `RCS_SP_RTS:   sp_out <= sp_move(sp_out, 3'd0, `RCS_CALL_PUSH);
                        default:       sp_out <= sp_out;
                    endcase
                end
            end
            if (any_rst) begin
                // Every reset source restores the same defined state.
                irq_pend_out   <= 8'h00;             // [RL1]
                irq_mask_out   <= 8'hFF;             // [RL1]
                ddr_out        <= 8'h00;             // [RL2]
                sp_out         <= `RCS_SP_TOP;       // [RL3]
                halt_out       <= 1'b0;              // [RL4] [RL10]
                idle_out       <= 1'b0;              // [RL4] [RL10]
                core_reset_out <= 1'b1;
                vec_fetch_out  <= 1'b0;
                vec_ok_r       <= 1'b0;
                if (state_r != ST_POR)
                    state_r <= ST_HOLD;
            end
            case (state_r)
                ST_POR: begin
                    // Stretch counts internal cycles, not oscillator cycles.
                    // Done on the 1920th tick itself, so the hold spans full cycles
                    if (!STATIC_VARIANT || (tick && por_cnt_r == `RCS_POR_CYCLES - 11'd1)) begin
                        por_done_r <= 1'b1;
                        state_r    <= ST_HOLD;              // [RL8]
                    end else if (tick) begin
                        por_cnt_r <= por_cnt_r + 11'd1;     // [RL8]
                    end
                end
                ST_HOLD: begin
                    if (!any_rst) begin                     // [RL9] [RL21]
                        state_r       <= ST_VECHI;
                        vec_fetch_out <= 1'b1;
                        vec_addr_out  <= `RCS_VEC_HI;
                    end
                end
                ST_VECHI: begin
                    if (vec_valid_in && !any_rst) begin     // [RL5]
                        vec_hi_r     <= vec_data_in;
                        vec_addr_out <= `RCS_VEC_LO;
                        state_r      <= ST_VECLO;
                    end
                end
                ST_VECLO: begin
                    if (vec_valid_in && !any_rst) begin     // [RL5]
                        pc_out         <= {vec_hi_r[4:0], vec_data_in}; // [RL19]
                        vec_fetch_out  <= 1'b0;
                        vec_ok_r       <= 1'b1;
                        core_reset_out <= 1'b0;
                        state_r        <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // A reset while running goes back through hold and a fresh fetch
                    if (any_rst)
                        state_r <= ST_HOLD;
                end
                default: state_r <= ST_POR;
            endcase
        end
    end

    // Register reads share the one map the core sees; no separate I/O space.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (ce_in && hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
            case (haddr_in[7:0])                                    // [RL20]
                `RCS_REG_CTRL:   hrdata_out <= {24'h00_0000, ctrl_r};
                `RCS_REG_STATUS: hrdata_out <= {27'h000_0000, por_done_r, vec_ok_r,
                                                idle_out, halt_out, core_reset_out};
                `RCS_REG_SP:     hrdata_out <= {19'h0_0000, sp_out};
                `RCS_REG_PC:     hrdata_out <= {19'h0_0000, pc_out};
                `RCS_REG_IRQ:    hrdata_out <= {16'h0000, irq_mask_out, irq_pend_out};
                `RCS_REG_DDR:    hrdata_out <= {24'h00_0000, ddr_out};
                default:         hrdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule // rcs_ctrl

// ### test/rcs_ctrl_chk.sv
// Port checker for rcs_ctrl, bound to every instance.
// Assumes ce_in stays high, so the tick period is fixed.
`timescale 1ns/1ns
module rcs_ctrl_chk #(
    parameter STATIC_VARIANT = 1'b1,
    parameter DIV2_OPTION    = 1'b0
) (
    input wire        mclk_in,
    input wire        rst_b_in,
    input wire        ext_reset_b_in,
    input wire        supply_drop_detector_in,
    input wire        hreadyout_out,
    input wire        hresp_out,
    input wire        core_reset_out,
    input wire        vec_fetch_out,
    input wire [12:0] vec_addr_out,
    input wire [12:0] sp_out,
    input wire [7:0]  irq_pend_out,
    input wire [7:0]  irq_mask_out,
    input wire [7:0]  ddr_out,
    input wire        halt_out,
    input wire        idle_out,
    input wire        sys_tick_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // A cycle of grace after reset rises lets the clear land
    irq_rst_a: assert property (
        $past(core_reset_out) && core_reset_out |-> irq_pend_out == 8'h00 && irq_mask_out == 8'hFF)
        else $error("irq state wrong in reset");
    ddr_rst_a: assert property (
        $past(core_reset_out) && core_reset_out |-> ddr_out == 8'h00)
        else $error("direction bits not cleared");
    sp_rst_a: assert property (
        $past(core_reset_out) && core_reset_out |-> sp_out == 13'h007F)
        else $error("stack pointer not at top");
    low_power_clr_a: assert property (
        $past(core_reset_out) && core_reset_out |-> !halt_out && !idle_out)
        else $error("halt or idle kept in reset");
    pin_hold_a: assert property (
        (!ext_reset_b_in) [*5] |-> core_reset_out)
        else $error("low pin without reset");
    drop_hold_a: assert property (
        supply_drop_detector_in [*5] |-> core_reset_out)
        else $error("supply drop without reset");
    vec_start_a: assert property (
        $rose(vec_fetch_out) |-> vec_addr_out == 13'h1FFE && core_reset_out)
        else $error("vector fetch starts wrong");
    vec_done_a: assert property (
        $rose(vec_fetch_out) |-> ##[1:40] !vec_fetch_out)
        else $error("vector fetch never ends");
    sp_window_a: assert property (
        sp_out >= 13'h0060 && sp_out <= 13'h007F)
        else $error("stack pointer left its window");
    tick_gap_a: assert property (
        sys_tick_out && !(STATIC_VARIANT && DIV2_OPTION) |=> !sys_tick_out [*3] ##1 sys_tick_out)
        else $error("tick period not four");
    bus_okay_a: assert property (
        hreadyout_out && !hresp_out)
        else $error("bus answer not ready okay");
endmodule // rcs_ctrl_chk

bind rcs_ctrl rcs_ctrl_chk #(.STATIC_VARIANT(STATIC_VARIANT), .DIV2_OPTION(DIV2_OPTION)) u_chk (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ext_reset_b_in(ext_reset_b_in),
    .supply_drop_detector_in(supply_drop_detector_in), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .core_reset_out(core_reset_out), .vec_fetch_out(vec_fetch_out),
    .vec_addr_out(vec_addr_out), .sp_out(sp_out), .irq_pend_out(irq_pend_out),
    .irq_mask_out(irq_mask_out), .ddr_out(ddr_out), .halt_out(halt_out),
    .idle_out(idle_out), .sys_tick_out(sys_tick_out));

// ### test/rcs_ext.sv
// Reset circuit, supply monitor and vector memory outside the block.
// Vector bytes answer three cycles after the address settles.
`timescale 1ns/1ns
module rcs_ext (
    input  wire        mclk_in,
    input  wire        pin_low_in,
    input  wire        drop_in,
    input  wire        fetch_in,
    input  wire [12:0] addr_in,
    output reg         ext_reset_b_out,
    output reg         drop_out,
    output reg  [7:0]  vec_data_out,
    output reg         vec_valid_out
);
    reg [1:0] wait_r;
    initial begin
        ext_reset_b_out = 1'b1;
        drop_out = 1'b0;
        vec_data_out = 8'h00;
        vec_valid_out = 1'b0;
        wait_r = 2'h0;
    end
    always @(posedge mclk_in) begin
        ext_reset_b_out <= !pin_low_in;
        drop_out <= drop_in;
        wait_r <= (fetch_in && !vec_valid_out) ? wait_r + 2'h1 : 2'h0;
        vec_valid_out <= fetch_in && !vec_valid_out && wait_r == 2'h2;
        // Bus toggles when idle so a stale byte never looks valid
        vec_data_out <= (fetch_in && wait_r == 2'h2) ? (addr_in[0] ? 8'h34 : 8'h12) : ~vec_data_out;
    end
endmodule // rcs_ext

// ### test/reset_clock_stack_control_tb.sv
// Bench for rcs_ctrl: bus, stack and reset sources in sequence.
// Assumes rcs_ext answers every vector fetch.
`timescale 1ns/1ns
`include "rcs_map.vh"
module reset_clock_stack_control_tb;
    reg         mclk_in = 1'b0, rst_b_in = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg         pin_low = 1'b0, drop = 1'b0;
    reg  [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q;
    reg  [1:0]  htrans = 2'h0;
    reg  [2:0]  sp_op = 3'h0;
    reg  [7:0]  irq_set = 8'h00;
    wire [31:0] hrdata;
    wire [12:0] vaddr, pc, sp;
    wire [7:0]  vdata, pend, mask, ddr;
    wire        rdy, erst_b, sdd, vvalid, crst, vfetch, halt, idle, xsel, tick;
    integer     failures = 0, checks = 0, n;
    always #20 mclk_in = ~mclk_in;
    rcs_ctrl uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
        .ext_reset_b_in(erst_b), .supply_drop_detector_in(sdd), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(rdy), .hrdata_out(hrdata), .hreadyout_out(rdy),
        .hresp_out(), .sp_op_in(sp_op), .irq_set_in(irq_set), .core_reset_out(crst),
        .vec_fetch_out(vfetch), .vec_addr_out(vaddr), .vec_data_in(vdata),
        .vec_valid_in(vvalid), .pc_out(pc), .sp_out(sp), .irq_pend_out(pend),
        .irq_mask_out(mask), .ddr_out(ddr), .halt_out(halt), .idle_out(idle),
        .osc_xtal_sel_out(xsel), .sys_tick_out(tick));
    rcs_ext ext (.mclk_in(mclk_in), .pin_low_in(pin_low), .drop_in(drop), .fetch_in(vfetch),
        .addr_in(vaddr), .ext_reset_b_out(erst_b), .drop_out(sdd), .vec_data_out(vdata),
        .vec_valid_out(vvalid));
    task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task ahb(input wr, input [31:0] a, input [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
        @(posedge mclk_in);
        while (rdy !== 1'b1) @(posedge mclk_in);
        htrans <= 2'h0; hwdata <= d;
        @(posedge mclk_in);
        while (rdy !== 1'b1) @(posedge mclk_in);
        q = hrdata;
    endtask
    task wait_run(input integer lim);
        n = 0;
        while (crst !== 1'b0 && n < lim) begin
            @(posedge mclk_in);
            n = n + 1;
        end
    endtask
    // Op spans one full tick period, so exactly one tick sees it
    task sp_chk(input [2:0] op, input [12:0] exp);
        @(posedge mclk_in);
        while (tick !== 1'b1) @(posedge mclk_in);
        sp_op <= op;
        repeat (4) @(posedge mclk_in);
        sp_op <= 3'h0;
        repeat (2) @(posedge mclk_in);
        chk(sp, exp, "sp");
    endtask
    task rst_state;
        chk({crst, halt, idle, pend, mask, ddr}, {3'b100, 24'h00FF00}, "rststate");
        chk(sp, 13'h007F, "rst_sp");
    endtask
    task stop_test;
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge mclk_in);
        failures = failures + 1;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        @(posedge mclk_in);
        rst_state;
        wait_run(9000);
        chk(n >= 7688 && n < 7720, 1, "por_len");
        chk(pc, 13'h1234, "pc");
        sp_chk(`RCS_SP_INTR, 13'h007A);
        sp_chk(`RCS_SP_CALL, 13'h0078);
        sp_chk(`RCS_SP_RTS, 13'h007A);
        sp_chk(`RCS_SP_RTI, 13'h007F);
        sp_chk(`RCS_SP_POP1, 13'h007F);
        sp_chk(`RCS_SP_PUSH1, 13'h007E);
        sp_chk(`RCS_SP_POP1, 13'h007F);
        repeat (6) sp_chk(`RCS_SP_INTR, sp - 13'h0005);
        sp_chk(`RCS_SP_CALL, 13'h007F);
        ahb(1'b1, `RCS_REG_SP, 32'h0000_0070);
        ahb(1'b0, `RCS_REG_SP, 32'h0000_0000);
        chk(q, 32'h0000_007F, "sp_rd");
        ahb(1'b1, `RCS_REG_DDR, 32'h0000_00A5);
        ahb(1'b1, `RCS_REG_IRQ, 32'h0000_3C00);
        irq_set <= 8'h81;
        ahb(1'b1, `RCS_REG_CTRL, 32'h0000_000D);
        irq_set <= 8'h00;
        ahb(1'b0, `RCS_REG_IRQ, 32'h0000_0000);
        chk(q, 32'h0000_3C81, "irq_rd");
        ahb(1'b0, `RCS_REG_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_001E, "status");
        ahb(1'b0, `RCS_REG_PC, 32'h0000_0000);
        chk(q, 32'h0000_1234, "pc_rd");
        ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
        chk(q, 32'h0000_0000, "unmapped");
        chk({xsel, halt, idle, ddr}, 11'h7A5, "ctrl");
        pin_low <= 1'b1;
        repeat (8) @(posedge mclk_in);
        rst_state;
        pin_low <= 1'b0;
        wait_run(9000);
        chk(crst, 1'b0, "pin_rel");
        drop <= 1'b1;
        repeat (8) @(posedge mclk_in);
        chk(crst, 1'b1, "drop");
        drop <= 1'b0;
        wait_run(9000);
        chk(crst, 1'b0, "drop_rel");
        ahb(1'b1, `RCS_REG_CTRL, 32'h0000_0010);
        repeat (2) @(posedge mclk_in);
        chk(crst, 1'b1, "swrst");
        wait_run(100);
        chk(crst, 1'b0, "swrst_up");
        pin_low <= 1'b1;
        rst_b_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (8000) @(posedge mclk_in);
        chk(crst, 1'b1, "pin_hold");
        pin_low <= 1'b0;
        wait_run(100);
        chk(crst, 1'b0, "pin_up");
        stop_test;
    end
endmodule // reset_clock_stack_control_tb
